// ---- verilog/rsr_defs.vh ----
// What this block does
// - Trigger-conversion command starts one conversion; 8-bit result goes to readout field.
// - Result becomes valid 20 us after the trigger; host waits that long.
// - Converter source follows the four-bit select field captured at trigger time.
// - Sources include both receive mixer DC outputs and the external converter pin.
// - Readout register shows result on page 00, oscillator and supply on page 01.
// - Page 01 bit 7: 0 crystal coupled, 1 input tied to ground.
// - Page 01 bits 2..0: supply setting in use, 2.7 V plus 0.1 V steps.
// - Page 01 bits 6..3 read zero.
// - Status bit 6 set, interrupt raised, when oscillator range selection completes.
// - Status bit 5 set, interrupt raised, when supply level setting completes.
// - Status bit 4 set, interrupt raised, when filter calibration completes.
// - Status bit 3 set, interrupt raised, when triggered conversion completes.
// - Status bit 2 reads 1 while anti-collision support is enabled.
// - Status bit 1 shows gain limiter active after limiter on/off commands.
// - Status bit 0 shows auxiliary synthesizer selected after hop commands.
// - Command status register is read-only; bit 7 reads zero.
// - Version register returns a fixed 8-bit code on every read.
// - Interrupt pin rises only for enabled events; flags always recorded.
`ifndef RSR_DEFS_VH
`define RSR_DEFS_VH

// Register indices, byte address is four times the index
`define RSR_IDX_READOUT 6'h2d
`define RSR_IDX_CMDSTAT 6'h2e
`define RSR_IDX_VERSION 6'h33
`define RSR_IDX_CMD 6'h3a
`define RSR_IDX_CTRL 6'h3b
`define RSR_IDX_IRQ_STAT 6'h3c
`define RSR_IDX_IRQ_EN 6'h3d

// Direct command codes
`define RSR_CMD_HOP_MAIN 8'h84
`define RSR_CMD_HOP_AUX 8'h85
`define RSR_CMD_CONV 8'h87
`define RSR_CMD_FCAL 8'h88
`define RSR_CMD_SUPP_AUTO 8'ha2
`define RSR_CMD_SUPP_MAN 8'ha3
`define RSR_CMD_VCO_AUTO 8'ha4
`define RSR_CMD_VCO_MAN 8'ha5
`define RSR_CMD_AGL_ON 8'ha6
`define RSR_CMD_AGL_OFF 8'ha7

// Readout pages
`define RSR_PAGE_RESULT 2'h0
`define RSR_PAGE_OSC 2'h1

// Control register fields
`define RSR_CTRL_PAGE_LSB 0
`define RSR_CTRL_PAGE_MSB 1
`define RSR_CTRL_ACOL_BIT 4
`define RSR_CTRL_MSEL_LSB 8
`define RSR_CTRL_MSEL_MSB 11
`define RSR_CTRL_RESET 32'h0000_0000
`define RSR_CTRL_MASK 32'h0000_0f13

// Command status bit positions
`define RSR_ST_VCO 6
`define RSR_ST_SUPP 5
`define RSR_ST_FCAL 4
`define RSR_ST_CONV 3
`define RSR_ST_ACOL 2
`define RSR_ST_AGL 1
`define RSR_ST_AUX 0
`define RSR_EV_LSB 3
`define RSR_EV_MSB 6
`define RSR_IRQ_EN_RESET 4'hf

// Converter source codes
`define RSR_MSEL_MIX_I 4'h0
`define RSR_MSEL_MIX_Q 4'h1
`define RSR_MSEL_EXT_PIN 4'h2

// Conversion timing
`define RSR_CLK_MHZ 25
`define RSR_CONV_TIME_US 20
`define RSR_CONV_CYCLES (`RSR_CONV_TIME_US * `RSR_CLK_MHZ)
`define RSR_CONV_CNT_W 9

`endif

// ---- verilog/rsr_conv.v ----
`timescale 1ns/1ps
`include "rsr_defs.vh"
module rsr_conv (
  ref_clk,
  sys_rst,
  start,
  sample,
  result,
  done,
  busy
);
  input wire ref_clk;
  input wire sys_rst;
  input wire start;
  input wire [7:0] sample;
  output reg [7:0] result;
  output reg done;
  output reg busy;

  localparam integer LAST_INT = `RSR_CONV_CYCLES - 1;
  localparam [`RSR_CONV_CNT_W-1:0] LAST_CNT = LAST_INT[`RSR_CONV_CNT_W-1:0];

  reg [`RSR_CONV_CNT_W-1:0] cnt_r;

  // Waits the conversion time, then captures the settled sample
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      result <= 8'h00;
      done <= 1'b0;
      busy <= 1'b0;
      cnt_r <= {`RSR_CONV_CNT_W{1'b0}};
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy <= 1'b1;
        cnt_r <= {`RSR_CONV_CNT_W{1'b0}};
      end
      else if (busy)
      begin
        if (cnt_r == LAST_CNT)
        begin
          busy <= 1'b0;
          result <= sample;
          done <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule // rsr_conv

// ---- verilog/rsr_regs.v ----
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "rsr_defs.vh"
module rsr_regs #(
  parameter [7:0] VERSION_CODE = 8'h5a // Arbitrary value
) (
  ref_clk,
  sys_rst,
  paddr,
  psel,
  penable,
  pwrite,
  pwdata,
  prdata,
  pready,
  pslverr,
  adc_value,
  osc_input_pin,
  supply_level_setting,
  fcal_done_in,
  supp_done_in,
  vco_done_in,
  adc_src_sel,
  adc_start,
  fcal_start,
  supp_start,
  supp_auto,
  vco_start,
  vco_auto,
  agl_en,
  aux_pll_sel,
  irq
);
  input wire ref_clk;
  input wire sys_rst;
  input wire [7:0] paddr;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output reg pslverr;
  input wire [7:0] adc_value;
  input wire osc_input_pin;
  input wire [2:0] supply_level_setting;
  input wire fcal_done_in;
  input wire supp_done_in;
  input wire vco_done_in;
  output reg [3:0] adc_src_sel;
  output reg adc_start;
  output reg fcal_start;
  output reg supp_start;
  output reg supp_auto;
  output reg vco_start;
  output reg vco_auto;
  output reg agl_en;
  output reg aux_pll_sel;
  output reg irq;

  localparam SYNC_W = 15;

  reg [SYNC_W-1:0] meta_r;
  reg [SYNC_W-1:0] sync_r;
  reg [2:0] done_prev_r;
  reg [31:0] ctrl_r;
  reg [3:0] irq_en_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_stat_nxt;
  reg [3:0] flag_r;
  reg [3:0] flag_nxt;
  reg [31:0] rd_nxt;
  reg map_ok;

  wire [SYNC_W-1:0] pin_in;
  wire [7:0] adc_s;
  wire osc_s;
  wire [2:0] vs_s;
  wire [2:0] done_s;
  wire [2:0] done_rise;
  wire [5:0] idx;
  wire acc;
  wire wr;
  wire cmd_go;
  wire [7:0] cmd_code;
  wire [3:0] issue;
  wire [3:0] ev;
  wire [1:0] page;
  wire [7:0] readout;
  wire [7:0] cmdstat;
  wire [7:0] conv_result;
  wire conv_done;

  // Two-stage synchronisers on every pin input
  assign pin_in = {vco_done_in, supp_done_in, fcal_done_in, supply_level_setting, osc_input_pin, adc_value};

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g = g + 1)
    begin : g_sync
      always @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end
        else
        begin
          meta_r[g] <= pin_in[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign adc_s = sync_r[7:0];
  assign osc_s = sync_r[8];
  assign vs_s = sync_r[11:9];
  assign done_s = sync_r[14:12];
  assign done_rise = done_s & ~done_prev_r;

  // APB decode; answers in the first access cycle
  assign idx = paddr[7:2];
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign pready = 1'b1;
  assign cmd_go = wr && map_ok && (idx == `RSR_IDX_CMD);
  assign cmd_code = pwdata[7:0];
  assign page = ctrl_r[`RSR_CTRL_PAGE_MSB:`RSR_CTRL_PAGE_LSB];

  // Command issue per event flag: vco, supply, calibration, conversion
  assign issue[`RSR_ST_VCO - `RSR_EV_LSB] = cmd_go &&
    (cmd_code == `RSR_CMD_VCO_AUTO || cmd_code == `RSR_CMD_VCO_MAN);
  assign issue[`RSR_ST_SUPP - `RSR_EV_LSB] = cmd_go &&
    (cmd_code == `RSR_CMD_SUPP_AUTO || cmd_code == `RSR_CMD_SUPP_MAN);
  assign issue[`RSR_ST_FCAL - `RSR_EV_LSB] = cmd_go && (cmd_code == `RSR_CMD_FCAL);
  assign issue[`RSR_ST_CONV - `RSR_EV_LSB] = cmd_go && (cmd_code == `RSR_CMD_CONV);

  // Completion events
  assign ev[`RSR_ST_VCO - `RSR_EV_LSB] = done_rise[2];
  assign ev[`RSR_ST_SUPP - `RSR_EV_LSB] = done_rise[1];
  assign ev[`RSR_ST_FCAL - `RSR_EV_LSB] = done_rise[0];
  assign ev[`RSR_ST_CONV - `RSR_EV_LSB] = conv_done;

  rsr_conv u_conv (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(adc_start),
    .sample(adc_s),
    .result(conv_result),
    .done(conv_done),
    .busy()
  );

  // Readout page mux
  assign readout = (page == `RSR_PAGE_RESULT) ? conv_result :
    (page == `RSR_PAGE_OSC) ? {osc_s, 4'h0, vs_s} :
    8'h00;

  assign cmdstat = {1'b0, flag_r, ctrl_r[`RSR_CTRL_ACOL_BIT], agl_en, aux_pll_sel};

  // Completion flags: clear on reissue, set wins
  always @*
  begin
    flag_nxt = (flag_r & ~issue) | ev;
    irq_stat_nxt = irq_stat_r | ev;
    if (wr && map_ok && idx == `RSR_IDX_IRQ_STAT)
    begin
      irq_stat_nxt = (irq_stat_r & ~pwdata[`RSR_EV_MSB:`RSR_EV_LSB]) | ev;
    end
  end

  // Read data and address map
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    map_ok = 1'b1;
    case (idx)
      `RSR_IDX_READOUT: rd_nxt = {24'h000000, readout};
      `RSR_IDX_CMDSTAT: rd_nxt = {24'h000000, cmdstat};
      `RSR_IDX_VERSION: rd_nxt = {24'h000000, VERSION_CODE};
      `RSR_IDX_CMD: rd_nxt = 32'h0000_0000;
      `RSR_IDX_CTRL: rd_nxt = ctrl_r;
      `RSR_IDX_IRQ_STAT: rd_nxt = {25'h0000000, irq_stat_r, 3'h0};
      `RSR_IDX_IRQ_EN: rd_nxt = {25'h0000000, irq_en_r, 3'h0};
      default: map_ok = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0)
    begin
      map_ok = 1'b0;
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      done_prev_r <= 3'h0;
      ctrl_r <= `RSR_CTRL_RESET;
      irq_en_r <= `RSR_IRQ_EN_RESET;
      irq_stat_r <= 4'h0;
      flag_r <= 4'h0;
      adc_src_sel <= `RSR_MSEL_MIX_I;
      adc_start <= 1'b0;
      fcal_start <= 1'b0;
      supp_start <= 1'b0;
      supp_auto <= 1'b0;
      vco_start <= 1'b0;
      vco_auto <= 1'b0;
      agl_en <= 1'b0;
      aux_pll_sel <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      done_prev_r <= done_s;
      flag_r <= flag_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq <= |(irq_stat_nxt & irq_en_r);
      adc_start <= issue[`RSR_ST_CONV - `RSR_EV_LSB];
      fcal_start <= issue[`RSR_ST_FCAL - `RSR_EV_LSB];
      supp_start <= issue[`RSR_ST_SUPP - `RSR_EV_LSB];
      vco_start <= issue[`RSR_ST_VCO - `RSR_EV_LSB];
      if (psel && !penable)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
        pslverr <= ~map_ok;
      end
      if (wr && map_ok && idx == `RSR_IDX_CTRL)
      begin
        ctrl_r <= pwdata & `RSR_CTRL_MASK;
      end
      if (wr && map_ok && idx == `RSR_IDX_IRQ_EN)
      begin
        irq_en_r <= pwdata[`RSR_EV_MSB:`RSR_EV_LSB];
      end
      if (issue[`RSR_ST_CONV - `RSR_EV_LSB])
      begin
        adc_src_sel <= ctrl_r[`RSR_CTRL_MSEL_MSB:`RSR_CTRL_MSEL_LSB];
      end
      if (issue[`RSR_ST_SUPP - `RSR_EV_LSB])
      begin
        supp_auto <= (cmd_code == `RSR_CMD_SUPP_AUTO);
      end
      if (issue[`RSR_ST_VCO - `RSR_EV_LSB])
      begin
        vco_auto <= (cmd_code == `RSR_CMD_VCO_AUTO);
      end
      if (cmd_go && cmd_code == `RSR_CMD_AGL_ON)
      begin
        agl_en <= 1'b1;
      end
      if (cmd_go && cmd_code == `RSR_CMD_AGL_OFF)
      begin
        agl_en <= 1'b0;
      end
      if (cmd_go && cmd_code == `RSR_CMD_HOP_AUX)
      begin
        aux_pll_sel <= 1'b1;
      end
      if (cmd_go && cmd_code == `RSR_CMD_HOP_MAIN)
      begin
        aux_pll_sel <= 1'b0;
      end
    end
  end
endmodule // rsr_regs

// ---- test/rsr_regs_monitor.sv ----
`timescale 1ns/1ps
module rsr_regs_monitor #(
  parameter [7:0] VERSION_CODE = 8'h5a
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [3:0] adc_src_sel,
  input wire adc_start,
  input wire fcal_start,
  input wire supp_start,
  input wire supp_auto,
  input wire vco_start,
  input wire vco_auto,
  input wire agl_en,
  input wire aux_pll_sel
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // Command write taken at the access edge
  sequence s_cmd(c);
    psel && penable && pwrite && paddr == 8'he8 && pwdata[7:0] == c;
  endsequence
  sequence s_ver_rd;
    psel && !penable && !pwrite && paddr == 8'hcc;
  endsequence
  a_conv_pulse: assert property (s_cmd(8'h87) |=> adc_start ##1 !adc_start)
    else $error("conversion start pulse wrong");
  a_src_hold: assert property (!adc_start |-> $stable(adc_src_sel))
    else $error("source select moved without trigger");
  a_fcal_pulse: assert property (s_cmd(8'h88) |=> fcal_start ##1 !fcal_start)
    else $error("calibration start pulse wrong");
  a_supp_auto: assert property (s_cmd(8'ha2) |=> supp_start && supp_auto)
    else $error("auto supply command wrong");
  a_vco_man: assert property (s_cmd(8'ha5) |=> vco_start && !vco_auto)
    else $error("manual range command wrong");
  a_agl_off: assert property (s_cmd(8'ha7) |=> !agl_en)
    else $error("limiter still active");
  a_hop_aux: assert property (s_cmd(8'h85) |=> aux_pll_sel)
    else $error("auxiliary setting not selected");
  a_version_read: assert property (s_ver_rd |=> prdata == {24'h0, VERSION_CODE})
    else $error("version code wrong");
endmodule // rsr_regs_monitor
bind rsr_regs rsr_regs_monitor #(.VERSION_CODE(VERSION_CODE)) i_rsr_regs_monitor (.ref_clk, .sys_rst, .paddr,
  .psel, .penable, .pwrite, .pwdata, .prdata, .adc_src_sel, .adc_start, .fcal_start, .supp_start, .supp_auto,
  .vco_start, .vco_auto, .agl_en, .aux_pll_sel);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, serr = 0;
  reg osc_input_pin = 0, fcal_done_in = 0, supp_done_in = 0, vco_done_in = 0;
  reg [7:0] paddr = 0, adc_value = 0;
  reg [2:0] supply_level_setting = 0;
  reg [31:0] pwdata = 0, rd = 0;
  wire [31:0] prdata;
  wire [3:0] adc_src_sel;
  wire pready, pslverr, adc_start, fcal_start, supp_start, supp_auto, vco_start, vco_auto, agl_en;
  wire aux_pll_sel, irq;
  integer num_errors = 0, n_compared = 0, i;
  rsr_regs #(.VERSION_CODE(8'h3c)) i_rsr_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_value(adc_value), .osc_input_pin(osc_input_pin),
    .supply_level_setting(supply_level_setting), .fcal_done_in(fcal_done_in), .supp_done_in(supp_done_in),
    .vco_done_in(vco_done_in), .adc_src_sel(adc_src_sel), .adc_start(adc_start), .fcal_start(fcal_start),
    .supp_start(supp_start), .supp_auto(supp_auto), .vco_start(vco_start), .vco_auto(vco_auto),
    .agl_en(agl_en), .aux_pll_sel(aux_pll_sel), .irq(irq));
  initial forever #20 ref_clk = ~ref_clk;
  task end_sim;
    begin
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge ref_clk);
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge ref_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      @(posedge ref_clk);
      for (n = 0; pready !== 1'b1; n = n + 1)
      begin
        if (n > 20)
        begin
          num_errors = num_errors + 1;
          $display("[ERR] %0t no ready", $time);
          end_sim;
        end
        @(posedge ref_clk);
      end
      rd = prdata;
      serr = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      cyc(2);
      xfer(0, a, 0);
      chk(rd & m, e);
    end
  endtask
  task pulse(input [2:0] m);
    begin
      {vco_done_in, supp_done_in, fcal_done_in} <= m;
      cyc(3);
      {vco_done_in, supp_done_in, fcal_done_in} <= 3'h0;
      cyc(4);
    end
  endtask
  task t_ver;
    begin
      rchk(8'hcc, 32'hffffffff, 32'h3c);
      xfer(1, 8'hcc, 32'hff);
      rchk(8'hcc, 32'hffffffff, 32'h3c);
      xfer(1, 8'hb8, 32'hff);
      rchk(8'hb8, 32'hffffffff, 32'h0);
      xfer(0, 8'h10, 0);
      chk(serr, 1);
      xfer(0, 8'hcd, 0);
      chk(serr, 1);
      $display("t_ver done");
    end
  endtask
  task t_conv;
    begin
      adc_value <= 8'hc3;
      for (i = 0; i < 3; i = i + 1)
      begin
        xfer(1, 8'hec, i << 8);
        xfer(1, 8'he8, 32'h87);
        cyc(2);
        chk(adc_src_sel, i);
      end
      cyc(400);
      rchk(8'hb8, 32'h8, 32'h0);
      cyc(120);
      rchk(8'hb4, 32'hffffffff, 32'hc3);
      rchk(8'hb8, 32'h8, 32'h8);
      chk(irq, 1);
      xfer(1, 8'he8, 32'h87);
      rchk(8'hb8, 32'h8, 32'h0);
      cyc(520);
      xfer(1, 8'hf0, 32'h78);
      cyc(2);
      chk(irq, 0);
      $display("t_conv done");
    end
  endtask
  task t_page;
    begin
      osc_input_pin <= 1;
      supply_level_setting <= 3'h5;
      xfer(1, 8'hec, 32'h1);
      rchk(8'hb4, 32'hffffffff, 32'h85);
      osc_input_pin <= 0;
      supply_level_setting <= 3'h7;
      rchk(8'hb4, 32'hffffffff, 32'h07);
      xfer(1, 8'hec, 32'h2);
      rchk(8'hb4, 32'hffffffff, 32'h0);
      xfer(1, 8'hec, 32'h0);
      rchk(8'hb4, 32'hffffffff, 32'hc3);
      $display("t_page done");
    end
  endtask
  task t_irq;
    begin
      xfer(1, 8'hf4, 32'h0);
      pulse(3'h1);
      rchk(8'hb8, 32'h10, 32'h10);
      chk(irq, 0);
      xfer(1, 8'hf4, 32'h10);
      cyc(2);
      chk(irq, 1);
      xfer(1, 8'hf0, 32'h78);
      pulse(3'h6);
      rchk(8'hb8, 32'h60, 32'h60);
      chk(irq, 0);
      xfer(1, 8'he8, 32'h88);
      rchk(8'hb8, 32'h10, 32'h0);
      $display("t_irq done");
    end
  endtask
  task t_cmd;
    begin
      for (i = 8'ha2; i <= 8'ha5; i = i + 1)
        xfer(1, 8'he8, i);
      xfer(1, 8'he8, 32'ha6);
      rchk(8'hb8, 32'h3, 32'h2);
      xfer(1, 8'he8, 32'h85);
      rchk(8'hb8, 32'h3, 32'h3);
      xfer(1, 8'he8, 32'ha7);
      xfer(1, 8'he8, 32'h84);
      rchk(8'hb8, 32'h3, 32'h0);
      xfer(1, 8'hec, 32'h10);
      rchk(8'hb8, 32'h4, 32'h4);
      $display("t_cmd done");
    end
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 0;
    t_ver;
    t_conv;
    t_page;
    t_irq;
    t_cmd;
    end_sim;
  end
endmodule // testbench
